//--- hdl/opc_pkg.sv
// Package for the output port control block: register map, field layout,
// reset values and the carrier types shared by the top and its pin stage.
// Assumes one system clock and byte-wide register accesses.
`default_nettype none

package opc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W            = 24;
  localparam logic [23:0] ADDR_FLOAT_GRP_A  = 24'h00ff70;
  localparam logic [23:0] ADDR_FLOAT_GRP_B  = 24'h00ff71;
  localparam logic [23:0] ADDR_FLOAT_GRP_C  = 24'h00ff72;
  localparam logic [23:0] ADDR_OUT_SERIES0  = 24'h00ff73;
  localparam logic [23:0] ADDR_OUT_SERIES1  = 24'h00ff74;
  localparam logic [23:0] ADDR_OUT_SERIES2  = 24'h00ff75;
  localparam logic [23:0] ADDR_OUT_SERIES3  = 24'h00ff76;
  localparam int unsigned NUM_REGS          = 7;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int unsigned FLOAT_S0_LOW      = 0;
  localparam int unsigned FLOAT_S0_HIGH     = 1;
  localparam int unsigned FLOAT_S1_LOW      = 2;
  localparam int unsigned FLOAT_S1_HIGH     = 3;
  localparam int unsigned PINS_S0           = 8;
  localparam int unsigned PINS_S1           = 8;
  localparam int unsigned PINS_S2           = 6;
  localparam int unsigned PINS_S3           = 4;
  localparam int unsigned NUM_PINS          = 26;

  // ----------------------------------------------------------------------
  // Reset values: unused bits are plain storage that reset to zero
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_FLOAT         = 8'h00;
  localparam logic [7:0]  RST_OUT_S0        = 8'hff;
  localparam logic [7:0]  RST_OUT_S1        = 8'hff;
  localparam logic [7:0]  RST_OUT_S2        = 8'h3f;
  localparam logic [7:0]  RST_OUT_S3        = 8'h0f;
  localparam logic [7:0]  RD_UNMAPPED       = 8'h00;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } opc_bus_req_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] drive;
  } opc_pins_t;

  typedef struct packed {
    logic [PINS_S3-1:0] s3;
    logic [PINS_S2-1:0] s2;
    logic [PINS_S1-1:0] s1;
    logic [PINS_S0-1:0] s0;
  } opc_pinvec_t;

endpackage

`default_nettype wire

//--- hdl/opc_pin_stage.sv
// Pin stage: turns float-control and data bits into per-pin level/enable.
// Assumes the register bytes arrive already reset and stable per clock.
`default_nettype none

module opc_pin_stage
  import opc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_float_a,
  input  wire logic [7:0]  i_float_b,
  input  wire logic [7:0]  i_float_c,
  input  wire logic [7:0]  i_out_s0,
  input  wire logic [7:0]  i_out_s1,
  input  wire logic [7:0]  i_out_s2,
  input  wire logic [7:0]  i_out_s3,
  input  wire logic [3:0]  i_bus_pins,
  output var opc_pins_t    o_pins
);

  // ----------------------------------------------------------------------
  // Float expansion
  // ----------------------------------------------------------------------
  opc_pinvec_t float_vec;
  opc_pinvec_t data_vec;
  logic [NUM_PINS-1:0] bus_mask;

  always_comb begin
    float_vec.s0 = {{4{i_float_a[FLOAT_S0_HIGH]}}, {4{i_float_a[FLOAT_S0_LOW]}}}; // R1
    float_vec.s1 = {{4{i_float_a[FLOAT_S1_HIGH]}}, {4{i_float_a[FLOAT_S1_LOW]}}}; // R1
    float_vec.s2 = i_float_b[PINS_S2-1:0]; // R2
    float_vec.s3 = i_float_c[PINS_S3-1:0]; // R3
    data_vec.s0  = i_out_s0; // R7
    data_vec.s1  = i_out_s1; // R7
    data_vec.s2  = i_out_s2[PINS_S2-1:0]; // R8
    data_vec.s3  = i_out_s3[PINS_S3-1:0]; // R9
  end

  // Pins given to the bus function stop driving at the next enabled edge; reset still drives all pins
  assign bus_mask = {{PINS_S3{i_bus_pins[3]}}, {PINS_S2{i_bus_pins[2]}},
                     {PINS_S1{i_bus_pins[1]}}, {PINS_S0{i_bus_pins[0]}}};

  // ----------------------------------------------------------------------
  // Registered pin drivers
  // ----------------------------------------------------------------------
  // Level follows data even while floating, so release shows current data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pins.level <= '1;
      o_pins.drive <= '1;
    end else if (i_ce) begin
      o_pins.level <= data_vec; // R10 R15 R16
      o_pins.drive <= ~float_vec & ~bus_mask; // R4 R13 R14 R16
    end
  end

endmodule

`default_nettype wire

//--- hdl/opc_top.sv
// Output port control: 26 output pins with data and float-control bytes.
// Assumes a byte register port in the system clock domain; the pins'
// three-state wiring is resolved outside from level and enable.
//
// Functional notes
// [R1] One float bit per four pins of series 0 and 1, bits 0-3 of 00FF70.
// [R2] Individual float bits for pins 20-25, bits 0-5 of 00FF71.
// [R3] Individual float bits for pins 30-33, bits 0-3 of 00FF72.
// [R4] Float bit 1 puts its pins in high impedance; 0 drives them.
// [R5] Float bits are writable and read back the value written.
// [R6] Reset clears every float bit so all pins drive.
// [R7] Data for pins 0-7 at 00FF73 and 10-17 at 00FF74.
// [R8] Data for pins 20-25 in bits 0-5 of 00FF75.
// [R9] Data for pins 30-33 in bits 0-3 of 00FF76.
// [R10] Driving pin outputs high for data 1, low for 0; reads back.
// [R11] Reset sets every data bit to 1.
// [R12] Unused bits are plain storage, reset to 0, no pin effect.
// [R13] Data bits of bus-assigned pins stay storage without pin effect.
// [R14] Float bits of bus-assigned pins stay storage in expansion mode.
// [R15] Leaving high impedance shows the current data bit at once.
// [R16] Writes reach the pins at the clock edge after the write.
`default_nettype none

module opc_top
  import opc_pkg::*;
(
  input  wire logic                I_CLK,
  input  wire logic                I_RST_N,
  input  wire logic                I_CE,
  input  wire logic [ADDR_W-1:0]   I_ADDR,
  input  wire logic [7:0]          I_WDATA,
  input  wire logic                I_WR,
  input  wire logic                I_RD,
  input  wire logic [3:0]          I_BUS_PINS,
  output logic      [7:0]          O_RDATA,
  output logic      [NUM_PINS-1:0] O_PIN_OUT,
  output logic      [NUM_PINS-1:0] O_PIN_OE
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  opc_bus_req_t req;
  logic [7:0]   float_a;
  logic [7:0]   float_b;
  logic [7:0]   float_c;
  logic [7:0]   out_s0;
  logic [7:0]   out_s1;
  logic [7:0]   out_s2;
  logic [7:0]   out_s3;
  opc_pins_t    pins;

  assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

  function automatic logic hit(input opc_bus_req_t r, input logic [23:0] a);
    hit = r.addr == a;
  endfunction

  // Whole bytes are stored, reserved bits included, so they act as RAM
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      float_a <= RST_FLOAT; // R6 R12
      float_b <= RST_FLOAT; // R6 R12
      float_c <= RST_FLOAT; // R6 R12
    end else if (I_CE && req.wr) begin
      if (hit(req, ADDR_FLOAT_GRP_A)) begin
        float_a <= req.wdata; // R1 R5 R14
      end
      if (hit(req, ADDR_FLOAT_GRP_B)) begin
        float_b <= req.wdata; // R2 R5 R14
      end
      if (hit(req, ADDR_FLOAT_GRP_C)) begin
        float_c <= req.wdata; // R3 R5 R14
      end
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      out_s0 <= RST_OUT_S0; // R11
      out_s1 <= RST_OUT_S1; // R11
      out_s2 <= RST_OUT_S2; // R11 R12
      out_s3 <= RST_OUT_S3; // R11 R12
    end else if (I_CE && req.wr) begin
      if (hit(req, ADDR_OUT_SERIES0)) begin
        out_s0 <= req.wdata; // R7 R13
      end
      if (hit(req, ADDR_OUT_SERIES1)) begin
        out_s1 <= req.wdata; // R7 R13
      end
      if (hit(req, ADDR_OUT_SERIES2)) begin
        out_s2 <= req.wdata; // R8 R12 R13
      end
      if (hit(req, ADDR_OUT_SERIES3)) begin
        out_s3 <= req.wdata; // R9 R12 R13
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    unique case (req.addr)
      ADDR_FLOAT_GRP_A: next_rdata = float_a; // R5
      ADDR_FLOAT_GRP_B: next_rdata = float_b; // R5
      ADDR_FLOAT_GRP_C: next_rdata = float_c; // R5
      ADDR_OUT_SERIES0: next_rdata = out_s0; // R10
      ADDR_OUT_SERIES1: next_rdata = out_s1; // R10
      ADDR_OUT_SERIES2: next_rdata = out_s2; // R10
      ADDR_OUT_SERIES3: next_rdata = out_s3; // R10
      default:          next_rdata = RD_UNMAPPED;
    endcase
  end

  // Data stands in the cycle after the read strobe; later enabled edges clear it, disabled edges hold it
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_RDATA <= 8'h00;
    end else if (I_CE) begin
      O_RDATA <= req.rd ? next_rdata : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  opc_pin_stage u_pins (
    .i_clk      (I_CLK),
    .i_rst_n    (rst_n),
    .i_ce       (I_CE),
    .i_float_a  (float_a),
    .i_float_b  (float_b),
    .i_float_c  (float_c),
    .i_out_s0   (out_s0),
    .i_out_s1   (out_s1),
    .i_out_s2   (out_s2),
    .i_out_s3   (out_s3),
    .i_bus_pins (I_BUS_PINS),
    .o_pins     (pins)
  );

  assign O_PIN_OUT = pins.level;
  assign O_PIN_OE  = pins.drive;

endmodule

`default_nettype wire

//--- dv/opc_line_model.sv
// External device sharing the output lines: drives them while we float.
// Assumes level/enable come straight from the block's pin ports.
`default_nettype none
module opc_line_model (
  input  wire logic        i_clk,
  input  wire logic [25:0] i_level,
  input  wire logic [25:0] i_oe,
  output logic      [25:0] o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floated line toggles every cycle, so stale levels never pass
  logic [25:0] ext = '0;
  always @(posedge i_clk) ext <= ~o_line;
  always_comb o_line = (i_level & i_oe) | (ext & ~i_oe);
endmodule
`default_nettype wire

//--- dv/opc_checker.sv
// Port-level properties of the output port block.
// Assumes binding to opc_top with a single clock domain.
`default_nettype none
module opc_checker
  import opc_pkg::*;
(
  input  wire logic                I_CLK,
  input  wire logic                I_RST_N,
  input  wire logic                I_CE,
  input  wire logic [ADDR_W-1:0]   I_ADDR,
  input  wire logic [7:0]          I_WDATA,
  input  wire logic                I_WR,
  input  wire logic                I_RD,
  input  wire logic [3:0]          I_BUS_PINS,
  input  wire logic [7:0]          O_RDATA,
  input  wire logic [NUM_PINS-1:0] O_PIN_OUT,
  input  wire logic [NUM_PINS-1:0] O_PIN_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  logic quiet;
  logic wr_ok;
  logic mapped;
  assign quiet  = I_CE && I_BUS_PINS == 4'h0;
  assign wr_ok  = I_WR && quiet;
  assign mapped = I_ADDR inside {[ADDR_FLOAT_GRP_A:ADDR_OUT_SERIES3]};
  a_out_s0_write: assert property (
    wr_ok && I_ADDR == ADDR_OUT_SERIES0 ##1 quiet |=> O_PIN_OUT[7:0] == $past(I_WDATA, 2))
    else $error("series0 data not on pins");
  a_out_s2_write: assert property (
    wr_ok && I_ADDR == ADDR_OUT_SERIES2 ##1 quiet |=> O_PIN_OUT[21:16] == $past(I_WDATA[5:0], 2))
    else $error("series2 data not on pins");
  a_out_s3_write: assert property (
    wr_ok && I_ADDR == ADDR_OUT_SERIES3 ##1 quiet |=> O_PIN_OUT[25:22] == $past(I_WDATA[3:0], 2))
    else $error("series3 data not on pins");
  a_float_grp_a: assert property (
    wr_ok && I_ADDR == ADDR_FLOAT_GRP_A ##1 quiet |=> O_PIN_OE[15:0] ==
    {{4{!$past(I_WDATA[3], 2)}}, {4{!$past(I_WDATA[2], 2)}},
     {4{!$past(I_WDATA[1], 2)}}, {4{!$past(I_WDATA[0], 2)}}})
    else $error("group float bit wrong");
  a_float_grp_b: assert property (
    wr_ok && I_ADDR == ADDR_FLOAT_GRP_B ##1 quiet |=> O_PIN_OE[21:16] == ~$past(I_WDATA[5:0], 2))
    else $error("series2 float bits wrong");
  a_float_grp_c: assert property (
    wr_ok && I_ADDR == ADDR_FLOAT_GRP_C ##1 quiet |=> O_PIN_OE[25:22] == ~$past(I_WDATA[3:0], 2))
    else $error("series3 float bits wrong");
  a_read_back: assert property (
    I_WR && I_CE && mapped ##1 I_RD && I_CE && I_ADDR == $past(I_ADDR)
    |=> O_RDATA == $past(I_WDATA, 2)) else $error("read back differs");
  a_bus_no_drive: assert property (
    (I_CE && I_BUS_PINS[0]) [*3] |-> O_PIN_OE[7:0] == 8'h00) else $error("bus pins driven");
endmodule
bind opc_top opc_checker u_chk (.I_CLK, .I_RST_N, .I_CE, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .I_BUS_PINS, .O_RDATA, .O_PIN_OUT, .O_PIN_OE);
`default_nettype wire

//--- dv/tb_output_port_control.sv
// Self-checking bench for the output port block and its line partner.
// Assumes the byte register port and reset sync described for opc_top.
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_output_port_control;
  import opc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CLK = 0, I_RST_N = 0, I_CE = 1, I_WR = 0, I_RD = 0, rd_seen = 0;
  logic [23:0] I_ADDR = '0;
  logic [7:0]  I_WDATA = '0, e;
  logic [3:0]  I_BUS_PINS = '0;
  logic [25:0] O_PIN_OUT, O_PIN_OE, line;
  logic [7:0]  O_RDATA, m [7];
  logic [7:0]  exp_q [$];
  int n_fail = 0, checks_done = 0;
  opc_top uut (.I_CLK, .I_RST_N, .I_CE, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_BUS_PINS,
    .O_RDATA, .O_PIN_OUT, .O_PIN_OE);
  opc_line_model u_line (.i_clk(I_CLK), .i_level(O_PIN_OUT), .i_oe(O_PIN_OE), .o_line(line));
  initial forever #5 I_CLK = ~I_CLK;
  // -------------------------------------------------------------------
  // Read monitor: checks data in the cycle after each enabled strobe
  // -------------------------------------------------------------------
  always @(posedge I_CLK) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, O_RDATA)
    end
    rd_seen <= I_RD && I_CE;
  end
  task automatic cyc(input logic w, r, input logic [23:0] a, input logic [7:0] d, x);
    I_WR <= w;
    I_RD <= r;
    I_ADDR <= a;
    I_WDATA <= d;
    // Enable may change by NBA in this same step, so it is not read here
    if (r) exp_q.push_back(x);
    @(posedge I_CLK);
  endtask
  task automatic pins();
    logic [25:0] ov, oe;
    ov = {m[6][3:0], m[5][5:0], m[4], m[3]};
    oe = {~m[2][3:0], ~m[1][5:0], {4{~m[0][3]}}, {4{~m[0][2]}}, {4{~m[0][1]}}, {4{~m[0][0]}}};
    oe &= ~{{4{I_BUS_PINS[3]}}, {6{I_BUS_PINS[2]}}, {8{I_BUS_PINS[1]}}, {8{I_BUS_PINS[0]}}};
    `CHK("pin_oe", oe, O_PIN_OE)
    `CHK("pin_out", ov & oe, O_PIN_OUT & oe)
    `CHK("line", ov & oe, line & oe)
  endtask
  task automatic wrap_up();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    wrap_up();
  end
  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    void'($urandom(32'h7f23));
    m = '{RST_FLOAT, RST_FLOAT, RST_FLOAT, RST_OUT_S0, RST_OUT_S1, RST_OUT_S2, RST_OUT_S3};
    repeat (10) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    repeat (4) @(posedge I_CLK);
    for (int i = 0; i < 7; i++) cyc(0, 1, ADDR_FLOAT_GRP_A + 24'(i), '0, m[i]);
    repeat (2) cyc(0, 0, '0, '0, '0);
    pins();
    for (int k = 0; k < 6; k++) begin
      I_BUS_PINS <= k[0] ? (4'($urandom) | 4'h1) : 4'h0;
      for (int i = 0; i < 7; i++) begin
        m[i] = 8'($urandom);
        cyc(1, 0, ADDR_FLOAT_GRP_A + 24'(i), m[i], '0);
      end
      for (int i = 6; i >= 0; i--) cyc(0, 1, ADDR_FLOAT_GRP_A + 24'(i), '0, m[i]);
      repeat (3) cyc(0, 0, '0, '0, '0);
      pins();
    end
    cyc(1, 0, 24'h00ff77, 8'ha5, '0);
    cyc(0, 1, 24'h00ff77, '0, RD_UNMAPPED);
    cyc(0, 1, 24'h00ff6f, '0, RD_UNMAPPED);
    // Frozen clock enable must drop the write
    I_CE <= 1'b0;
    cyc(1, 0, ADDR_OUT_SERIES0, ~m[3], '0);
    I_CE <= 1'b1;
    cyc(0, 1, ADDR_OUT_SERIES0, '0, m[3]);
    repeat (3) cyc(0, 0, '0, '0, '0);
    wrap_up();
  end
endmodule
`default_nettype wire
